/* File: pkg/pca_defs.vh */
/*
 * Constants for the counter array with capture/compare modules.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef PCA_DEFS_VH
`define PCA_DEFS_VH

`define PCA_NUM_MOD      6
`define PCA_WD_MOD       5
// Time base clock source select
`define PCA_SRC_DIV12    3'h0
`define PCA_SRC_DIV4     3'h1
`define PCA_SRC_T0OVF    3'h2
`define PCA_SRC_EXTCNT   3'h3
`define PCA_SRC_SYSCLK   3'h4
`define PCA_SRC_XOSC8    3'h5
`define PCA_DIV12_LAST   4'hB
`define PCA_DIV4_LAST    4'h3
`define PCA_DIV8_LAST    4'h7
// Module modes
`define PCA_MODE_OFF     3'h0
`define PCA_MODE_CAPT    3'h1
`define PCA_MODE_SWTMR   3'h2
`define PCA_MODE_HSO     3'h3
`define PCA_MODE_FREQ    3'h4
`define PCA_MODE_PWM     3'h5
// Capture edge select bits
`define PCA_EDGE_POS     0
`define PCA_EDGE_NEG     1
// PWM width select
`define PCA_PWM_8        3'h0
`define PCA_PWM_9        3'h1
`define PCA_PWM_10       3'h2
`define PCA_PWM_11       3'h3
`define PCA_PWM_16       3'h4
// Reset values
`define PCA_CNT_RST      16'h0000
`define PCA_WD_LIMIT_RST 16'hFFFF

`endif

/* File: verilog/pca_module.v */
/*
 * One capture/compare module: capture, software timer, high-speed
 * output, frequency output and PWM. Assumes a synchronised, one-cycle
 * wide time base tick and an already synchronised capture input.
 */
`include "pca_defs.vh"

module pca_module (
    input  wire        sys_clk,
    input  wire        srst,
    input  wire [2:0]  mode,
    input  wire [1:0]  edge_sel,
    input  wire [2:0]  pwm_width,
    input  wire [15:0] cmp_val,
    input  wire        tick,
    input  wire [15:0] count,
    input  wire        cap_in,
    output reg  [15:0] cap_q,
    output reg         flag_q,
    output reg         out_q
);
    reg         cap_prev_q;
    reg  [7:0]  freq_cnt_q;
    wire        rise = cap_in & ~cap_prev_q;
    wire        fall = ~cap_in & cap_prev_q;
    wire        match = tick && (count == cmp_val);
    reg  [15:0] pwm_mask;
    reg  [15:0] pwm_cnt;
    reg  [15:0] pwm_cmp;

    always @* begin
        case (pwm_width)
            `PCA_PWM_8:  pwm_mask = 16'h00FF;
            `PCA_PWM_9:  pwm_mask = 16'h01FF;
            `PCA_PWM_10: pwm_mask = 16'h03FF;
            `PCA_PWM_11: pwm_mask = 16'h07FF;
            default:     pwm_mask = 16'hFFFF;
        endcase
        pwm_cnt = count & pwm_mask;
        pwm_cmp = cmp_val & pwm_mask;
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            cap_prev_q <= 1'b0;
            cap_q      <= 16'h0000;
            flag_q     <= 1'b0;
            out_q      <= 1'b0;
            freq_cnt_q <= 8'h00;
        end else begin
            cap_prev_q <= cap_in;
            flag_q     <= 1'b0;
            case (mode)
                `PCA_MODE_CAPT: begin
                    if ((rise && edge_sel[`PCA_EDGE_POS]) ||
                        (fall && edge_sel[`PCA_EDGE_NEG])) begin
                        cap_q  <= count;
                        flag_q <= 1'b1;
                    end
                end
                `PCA_MODE_SWTMR: begin
                    if (match)
                        flag_q <= 1'b1;
                end
                `PCA_MODE_HSO: begin
                    if (match) begin
                        flag_q <= 1'b1;
                        out_q  <= ~out_q;
                    end
                end
                `PCA_MODE_FREQ: begin
                    // Half period is low byte of compare plus one, in time base ticks
                    if (tick) begin
                        if (freq_cnt_q == cmp_val[7:0]) begin
                            freq_cnt_q <= 8'h00;
                            out_q      <= ~out_q;
                        end else begin
                            freq_cnt_q <= freq_cnt_q + 8'h01;
                        end
                    end
                end
                `PCA_MODE_PWM: begin
                    out_q <= (pwm_cnt >= pwm_cmp);
                    if (tick && (pwm_cnt == pwm_mask))
                        flag_q <= 1'b1;
                end
                default: begin
                    out_q <= 1'b0;
                end
            endcase
        end
    end
endmodule

/* File: verilog/pca_top.v */
/*
 * Counter array: shared 16-bit time base, six capture/compare modules,
 * module five watchdog. Assumes pins reach it through the crossbar and
 * that por_rst comes from the power-on reset circuit.
 */
`include "pca_defs.vh"

module pca_top (
    input  wire        sys_clk,
    input  wire        srst,
    input  wire        por_rst,
    input  wire        run,
    input  wire [2:0]  clk_src,
    input  wire        t0_ovf,
    input  wire        external_count_input,
    input  wire        ext_osc,
    input  wire [17:0] mode_flat,
    input  wire [11:0] edge_flat,
    input  wire [17:0] pwm_flat,
    input  wire [95:0] cmp_flat,
    input  wire [5:0]  cap_pin,
    input  wire        wd_disable,
    input  wire        wd_service,
    input  wire [15:0] wd_limit,
    output reg  [15:0] count_q,
    output reg         ovf_q,
    output reg  [95:0] cap_flat_q,
    output reg  [5:0]  flag_q,
    output reg  [5:0]  out_pin_q,
    output reg         wd_active_q,
    output reg         wd_reset_q
);
    reg  [1:0]  eci_sync_q;
    reg  [1:0]  xosc_sync_q;
    reg  [11:0] cap_sync_q;
    reg         eci_prev_q;
    reg         xosc_prev_q;
    reg  [3:0]  pre_q;
    reg  [2:0]  xdiv_q;
    reg         tick;
    reg         tick_src;
    reg         wd_locked_q;
    reg         wd_en_q;
    reg  [15:0] wd_cnt_q;
    wire [95:0] mod_cap;
    wire [5:0]  mod_flag;
    wire [5:0]  mod_out;
    wire [5:0]  cap_in;
    wire        eci_rise  = eci_sync_q[1] & ~eci_prev_q;
    wire        xosc_rise = xosc_sync_q[1] & ~xosc_prev_q;
    integer     i;

    // Pins from the crossbar, two-stage synchronised
    always @(posedge sys_clk) begin
        if (srst) begin
            eci_sync_q  <= 2'b00;
            xosc_sync_q <= 2'b00;
            cap_sync_q  <= 12'h000;
            eci_prev_q  <= 1'b0;
            xosc_prev_q <= 1'b0;
        end else begin
            eci_sync_q  <= {eci_sync_q[0], external_count_input};
            xosc_sync_q <= {xosc_sync_q[0], ext_osc};
            for (i = 0; i < `PCA_NUM_MOD; i = i + 1) begin
                cap_sync_q[2*i]   <= cap_pin[i];
                cap_sync_q[2*i+1] <= cap_sync_q[2*i];
            end
            eci_prev_q  <= eci_sync_q[1];
            xosc_prev_q <= xosc_sync_q[1];
        end
    end

    genvar g;
    generate
        for (g = 0; g < `PCA_NUM_MOD; g = g + 1) begin : g_sync
            assign cap_in[g] = cap_sync_q[2*g+1];
        end
    endgenerate

    // Source select; prescaler free-runs so the counter steps once per period
    always @* begin
        case (clk_src)
            `PCA_SRC_DIV12:  tick_src = (pre_q == `PCA_DIV12_LAST);
            `PCA_SRC_DIV4:   tick_src = (pre_q[1:0] == `PCA_DIV4_LAST);
            `PCA_SRC_T0OVF:  tick_src = t0_ovf;
            `PCA_SRC_EXTCNT: tick_src = eci_rise;
            `PCA_SRC_SYSCLK: tick_src = 1'b1;
            `PCA_SRC_XOSC8:  tick_src = xosc_rise && (xdiv_q == `PCA_DIV8_LAST);
            default:         tick_src = 1'b0;
        endcase
        tick = tick_src & run;
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            pre_q   <= 4'h0;
            xdiv_q  <= 3'h0;
            count_q <= `PCA_CNT_RST;
            ovf_q   <= 1'b0;
        end else begin
            if (pre_q == `PCA_DIV12_LAST)
                pre_q <= 4'h0;
            else
                pre_q <= pre_q + 4'h1;
            if (xosc_rise)
                xdiv_q <= xdiv_q + 3'h1;
            ovf_q <= 1'b0;
            if (tick) begin
                count_q <= count_q + 16'h0001;
                if (count_q == 16'hFFFF)
                    ovf_q <= 1'b1;
            end
        end
    end

    generate
        for (g = 0; g < `PCA_NUM_MOD; g = g + 1) begin : g_mod
            pca_module u_mod (
                .sys_clk   (sys_clk),
                .srst      (srst),
                .mode      (mode_flat[3*g +: 3]),
                .edge_sel  (edge_flat[2*g +: 2]),
                .pwm_width (pwm_flat[3*g +: 3]),
                .cmp_val   (cmp_flat[16*g +: 16]),
                .tick      (tick),
                .count     (count_q),
                .cap_in    (cap_in[g]),
                .cap_q     (mod_cap[16*g +: 16]),
                .flag_q    (mod_flag[g]),
                .out_q     (mod_out[g])
            );
        end
    endgenerate

    // Lock survives system reset; only power-on reset clears it
    always @(posedge sys_clk) begin
        if (por_rst)
            wd_locked_q <= 1'b0;
        else if (wd_disable)
            wd_locked_q <= 1'b1;
    end

    always @(posedge sys_clk) begin
        if (srst || por_rst) begin
            // A locked watchdog must not come back for even one cycle
            wd_en_q    <= por_rst | ~wd_locked_q;
            wd_cnt_q   <= 16'h0000;
            wd_reset_q <= 1'b0;
        end else begin
            if (wd_disable || wd_locked_q)
                wd_en_q <= 1'b0;
            wd_reset_q <= 1'b0;
            if (!wd_en_q || wd_service) begin
                wd_cnt_q <= 16'h0000;
            end else if (tick) begin
                if (wd_cnt_q == wd_limit)
                    wd_reset_q <= 1'b1;
                else
                    wd_cnt_q <= wd_cnt_q + 16'h0001;
            end
        end
    end

    // Module five flag and output pin are overridden while the watchdog owns it
    always @(posedge sys_clk) begin
        if (srst) begin
            cap_flat_q  <= 96'h0;
            flag_q      <= 6'h00;
            out_pin_q   <= 6'h00;
            wd_active_q <= 1'b0;
        end else begin
            cap_flat_q  <= mod_cap;
            flag_q      <= mod_flag;
            out_pin_q   <= mod_out;
            wd_active_q <= wd_en_q;
            if (wd_en_q) begin
                flag_q[`PCA_WD_MOD]    <= 1'b0;
                out_pin_q[`PCA_WD_MOD] <= 1'b0;
            end
        end
    end
endmodule

/* File: test/cac_asserts.sv */
/* Checker for the counter array top, bound to its ports.
   Assumes one clock and a synchronous active-high reset. */
module cac_asserts (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        por_rst,
    input wire logic        run,
    input wire logic        wd_disable,
    input wire logic [2:0]  clk_src,
    input wire logic [11:0] edge_flat,
    input wire logic [5:0]  cap_pin,
    input wire logic [15:0] count_q,
    input wire logic        ovf_q,
    input wire logic [5:0]  flag_q,
    input wire logic [5:0]  out_pin_q,
    input wire logic        wd_active_q,
    input wire logic        wd_reset_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic lock_q;
    // Only power-on clears the lock
    always_ff @(posedge sys_clk) lock_q <= por_rst ? 1'b0 : lock_q | wd_disable;
    sequence s_por_off; por_rst ##1 !por_rst; endsequence
    sequence s_rise0; edge_flat[0] && $rose(cap_pin[0]); endsequence
    a_reset_clears: assert property ($fell(srst) |-> count_q == 16'h0000 && flag_q == 6'h00)
        else $error("outputs not clear after reset");
    a_src_sysclk: assert property ((run && clk_src == 3'h4) [*4] |=>
        count_q == $past(count_q) + 16'h0001) else $error("count missed a clock");
    a_run_stops: assert property ((!run) [*3] |=> $stable(count_q))
        else $error("count moved while stopped");
    a_capture_delay: assert property (s_rise0 |-> ##[3:6] flag_q[0])
        else $error("capture flag late");
    a_fall_ignored: assert property (edge_flat[1:0] == 2'h1 && $fell(cap_pin[0])
        |-> (!flag_q[0]) [*6]) else $error("unselected edge flagged");
    a_mod5_quiet: assert property (wd_active_q |-> !flag_q[5] && !out_pin_q[5])
        else $error("module five active under watchdog");
    a_fire_needs_wd: assert property (wd_reset_q |-> $past(wd_active_q))
        else $error("reset while watchdog off");
    a_wd_starts: assert property (s_por_off |-> ##[1:2] wd_active_q)
        else $error("watchdog not enabled after reset");
    a_lock_holds: assert property (lock_q && !por_rst |=> !wd_active_q)
        else $error("watchdog back on while locked");
    a_ovf_at_zero: assert property (ovf_q |-> count_q == 16'h0000)
        else $error("overflow without wrap");
endmodule
bind pca_top cac_asserts chk (.sys_clk, .srst, .por_rst, .run, .wd_disable, .clk_src, .ovf_q,
    .edge_flat, .cap_pin, .count_q, .flag_q, .out_pin_q, .wd_active_q, .wd_reset_q);

/* File: test/cac_pins.sv */
/* Pin-side model: capture pins, count input and oscillator.
   Assumes it shares the bench clock for pacing. */
module cac_pins (
    input  wire logic  sys_clk,
    output logic [5:0] cap_pin,
    output logic       external_count_input,
    output logic       ext_osc
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cap_pin = 6'h00;
        external_count_input = 1'b0;
        ext_osc = 1'b0;
    end
    task cap(input int g, input logic v);
        @(posedge sys_clk);
        cap_pin[g] <= v;
    endtask
    // Three cycles apart so the synchroniser sees every level
    task ext(input int n, input logic osc);
        repeat (2 * n) begin
            repeat (3) @(posedge sys_clk);
            if (osc) ext_osc <= ~ext_osc;
            else external_count_input <= ~external_count_input;
        end
    endtask
endmodule

/* File: test/counter_array_capture_compare_bench.sv */
/* Bench for the counter array top: sources, capture, modes, watchdog.
   Assumes the pin model and checker are compiled first. */
`include "pca_defs.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module counter_array_capture_compare_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0, srst = 1'b1, por_rst = 1'b1, run = 1'b0;
    logic        t0_ovf = 1'b0, wd_disable = 1'b0, wd_service = 1'b1;
    logic        external_count_input, ext_osc, wd_active_q, wd_reset_q, seen, last;
    logic [2:0]  clk_src = 3'h4;
    logic [5:0]  cap_pin, flag_q, out_pin_q;
    logic [11:0] edge_flat = 12'h000;
    logic [15:0] wd_limit = 16'h0008, count_q, c0;
    logic [17:0] mode_flat = 18'h00000, pwm_flat = 18'h00000;
    logic [95:0] cmp_flat = 96'h0, cap_flat_q;
    int          fails = 0, checks_done = 0, cycles = 0, k, hi, tg;
    wire [6:0]   ev = {wd_reset_q, flag_q};
    always #25 sys_clk = ~sys_clk;
    pca_top uut (.sys_clk, .srst, .por_rst, .run, .clk_src, .t0_ovf, .external_count_input,
        .ext_osc, .mode_flat, .edge_flat, .pwm_flat, .cmp_flat, .cap_pin, .wd_disable,
        .wd_service, .wd_limit, .count_q, .ovf_q(), .cap_flat_q, .flag_q, .out_pin_q,
        .wd_active_q, .wd_reset_q);
    cac_pins pins (.sys_clk, .cap_pin, .external_count_input, .ext_osc);
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task src(input logic [2:0] s);
        clk_src <= s;
        cyc(30);
        #1 c0 = count_q;
    endtask
    task gain(input int n, input logic [15:0] e);
        cyc(n);
        #1 `CHK(count_q - c0, e)
    endtask
    // Flags last one cycle, so every edge is polled
    task waitfor(input int n, input int g);
        seen = 1'b0;
        repeat (n) begin
            cyc(1);
            #1 seen |= ev[g];
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            tally_and_finish;
        end
    end
    initial begin
        cyc(3);
        srst <= 1'b0;
        por_rst <= 1'b0;
        #1 `CHK({count_q, flag_q}, 22'h000000)
        cyc(2);
        #1 `CHK(wd_active_q, 1'b1)
        cyc(1);
        run <= 1'b1;
        src(`PCA_SRC_SYSCLK);
        gain(48, 16'h0030);
        cyc(1);
        src(`PCA_SRC_DIV4);
        gain(48, 16'h000C);
        cyc(1);
        src(`PCA_SRC_DIV12);
        gain(48, 16'h0004);
        cyc(1);
        src(`PCA_SRC_T0OVF);
        repeat (10) begin
            cyc(1);
            t0_ovf <= ~t0_ovf;
        end
        gain(8, 16'h0005);
        cyc(1);
        src(`PCA_SRC_EXTCNT);
        pins.ext(3, 1'b0);
        gain(8, 16'h0003);
        cyc(1);
        src(`PCA_SRC_XOSC8);
        pins.ext(16, 1'b1);
        gain(8, 16'h0002);
        cyc(1);
        run <= 1'b0;
        clk_src <= `PCA_SRC_SYSCLK;
        cyc(4);
        #1 c0 = count_q;
        for (k = 0; k < 6; k++) begin
            cyc(1);
            mode_flat[3*k+:3] <= `PCA_MODE_CAPT;
            edge_flat[2*k+:2] <= 2'h1;
            pins.cap(k, 1'b1);
            waitfor(10, k);
            `CHK(seen, k != 5)
            if (k < 5) `CHK(cap_flat_q[16*k+:16], c0)
            pins.cap(k, 1'b0);
            waitfor(10, k);
            `CHK(seen, 1'b0)
        end
        cyc(1);
        run <= 1'b1;
        mode_flat[5:3] <= `PCA_MODE_PWM;
        mode_flat[11:9] <= `PCA_MODE_FREQ;
        pwm_flat[5:3] <= `PCA_PWM_8;
        cmp_flat[31:16] <= 16'h0080;
        cmp_flat[63:48] <= 16'h0004;
        cyc(20);
        #1 last = out_pin_q[3];
        hi = 0;
        tg = 0;
        repeat (1280) begin
            cyc(1);
            #1 hi += (out_pin_q[1] === 1'b1);
            tg += (out_pin_q[3] !== last);
            last = out_pin_q[3];
        end
        `CHK(hi, 640)
        `CHK(tg, 256)
        c0 = count_q;
        cyc(1);
        mode_flat[14:12] <= `PCA_MODE_SWTMR;
        cmp_flat[79:64] <= c0 + 16'h0020;
        mode_flat[8:6] <= `PCA_MODE_HSO;
        cmp_flat[47:32] <= c0 + 16'h0020;
        waitfor(40, 4);
        `CHK(seen, 1'b1)
        `CHK(out_pin_q[2], 1'b1)
        cyc(1);
        wd_service <= 1'b0;
        waitfor(30, 6);
        `CHK(seen, 1'b1)
        cyc(1);
        wd_service <= 1'b1;
        cyc(2);
        waitfor(30, 6);
        `CHK(seen, 1'b0)
        cyc(1);
        wd_disable <= 1'b1;
        cyc(1);
        wd_disable <= 1'b0;
        cyc(3);
        #1 `CHK(wd_active_q, 1'b0)
        cyc(1);
        srst <= 1'b1;
        cyc(3);
        srst <= 1'b0;
        cyc(3);
        #1 `CHK(wd_active_q, 1'b0)
        cyc(1);
        por_rst <= 1'b1;
        cyc(3);
        por_rst <= 1'b0;
        cyc(2);
        #1 `CHK(wd_active_q, 1'b1)
        tally_and_finish;
    end
endmodule
